// File: common/spbp_defs.svh
// spbp_defs.svh: offsets, field positions, reset values of the six-pin port.
// assumes byte-wide registers, one per aligned wishbone word.
`ifndef SPBP_DEFS_SVH
`define SPBP_DEFS_SVH

`define SPBP_NPINS 6
`define SPBP_IN_ONLY_BIT 3
// printed offset 0x05 is not a multiple of four: index, byte address is 4x
`define SPBP_IDX_PORT_DATA 8'h05
`define SPBP_IDX_DIR 8'h06
`define SPBP_IDX_PULLUP 8'h07
`define SPBP_IDX_OPTION 8'h08
`define SPBP_IDX_CHANGE_EN 8'h09
`define SPBP_IDX_ANALOG 8'h0A
`define SPBP_IDX_PERIPH 8'h0B
`define SPBP_IDX_STATUS 8'h0C
`define SPBP_GLOBAL_PULLUP_BIT 7
`define SPBP_EXT_RESET_EN_BIT 0
`define SPBP_FLAG_BIT 0
`define SPBP_DIR_RST 6'h3F
`define SPBP_PULLUP_RST 6'h37
`define SPBP_OPTION_RST 8'h80
`define SPBP_IN_ONLY_MASK 6'h08

`endif

// File: common/spbp_pkg.sv
// spbp_pkg.sv: types of the six-pin port.
// assumes nothing beyond a systemverilog compiler.
package spbp_pkg;
    typedef enum logic [1:0] {
        SPBP_IDLE = 2'b01,
        SPBP_ACK = 2'b10
    } spbp_bus_state_t;
endpackage

// File: common/spbp_sync_if.sv
// spbp_sync_if.sv: carries synchronised pin levels between the port modules.
// assumes one clock for both ends.
`timescale 1ns/1ps
interface spbp_sync_if #(parameter int NPINS = 6);
    logic [NPINS-1:0] level;
    modport src (output level);
    modport dst (input level);
endinterface

// File: dv/spbp_board.sv
// spbp_board.sv: board signals around the six port pins.
// assumes the bench sets what the far side drives on each pin.
`timescale 1ns/1ps
module spbp_board (
    input wire logic clk_i,
    input wire logic [5:0] pin_o,
    input wire logic [5:0] pin_oe_o,
    input wire logic [5:0] pullup_o,
    input wire logic [5:0] ext_en_i,
    input wire logic [5:0] ext_val_i,
    output logic [5:0] level_o
);
    // floating, unpulled pins wander so no stale level reads as valid
    logic [5:0] float_ff = 6'h15;
    always_ff @(posedge clk_i) begin
        float_ff <= ~float_ff;
    end
    // port drive wins, then the board, then the weak pull-up
    assign level_o = (pin_oe_o & pin_o) | (~pin_oe_o & ext_en_i & ext_val_i)
        | (~pin_oe_o & ~ext_en_i & (pullup_o | float_ff));
endmodule

// File: dv/spbp_port_checker.sv
// spbp_port_checker.sv: bus and pin assertions for the six-pin port.
// assumes it is bound to spbp_port and sees only its ports.
`timescale 1ns/1ps
module spbp_port_checker #(
    parameter int NPINS = 6
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic err_o,
    input wire logic [NPINS-1:0] pin_oe_o,
    input wire logic [NPINS-1:0] pullup_o,
    input wire logic [NPINS-1:0] periph_oe_i,
    input wire logic port_change_flag_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_answer; $rose(cyc_i && stb_i) && ce_i |=> ack_o || err_o; endproperty
    a_answer: assert property (p_answer) else $error("no answer one cycle after request");
    property p_pulse; ack_o || err_o |=> !ack_o && !err_o; endproperty
    a_pulse: assert property (p_pulse) else $error("answer longer than one cycle");
    property p_upper; ack_o && !we_i && adr_i == 8'h14 |-> dat_o[31:6] == '0; endproperty
    a_upper: assert property (p_upper) else $error("port read upper bits not zero");
    property p_in_only; !pin_oe_o[3]; endproperty
    a_in_only: assert property (p_in_only) else $error("input-only pin driven");
    property p_pu3; pullup_o[3] == 1'b0; endproperty
    a_pu3: assert property (p_pu3) else $error("pull-up on input-only pin");
    property p_pu_out; (pullup_o & pin_oe_o) == '0; endproperty
    a_pu_out: assert property (p_pu_out) else $error("pull-up on an output pin");
    property p_rst; $fell(rst_i) |-> pin_oe_o == '0 && pullup_o == '0 && !port_change_flag_o; endproperty
    a_rst: assert property (p_rst) else $error("pins or flag active after reset");
    property p_sticky; port_change_flag_o && !(cyc_i && stb_i && we_i) |=> port_change_flag_o; endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped without a write");
    cover property (ack_o && !we_i);
    cover property (err_o);
    cover property ($rose(port_change_flag_o));
endmodule
bind spbp_port spbp_port_checker #(.NPINS(NPINS)) spbp_port_checker_inst (.*);

// File: dv/tb_six_pin_bidir_port.sv
// tb_six_pin_bidir_port.sv: register and pin tests of the six-pin port.
// assumes spbp_port, spbp_board and the checker are compiled before it.
`timescale 1ns/1ps
module tb_six_pin_bidir_port;
    logic clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, ack_o, err_o, port_change_flag_o, e;
    logic [7:0] adr_i, q;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o;
    logic [5:0] pin_i, pin_o, pin_oe_o, pullup_o, periph_out_i, periph_oe_i, periph_in_o, ext_en, ext_val;
    int n_mismatch = 0;
    int checks_done = 0;
    spbp_port spbp_port_inst (.*);
    spbp_board spbp_board_inst (.*, .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(pin_i));
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, 4'h1, 24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 50);
        q = dat_o[7:0];
        e = err_o;
        {cyc_i, stb_i} <= 2'b00;
        chk("bus wait", 9'(n < 50), 9'h001);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        wb(1'b0, a, 8'h00);
        chk($sformatf("read %h", a), {e, q}, {1'b0, exp});
    endtask
    task automatic final_report();
        $display("checks_done %0d n_mismatch %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #100us;
        n_mismatch++;
        final_report();
    end
    initial begin
        {rst_i, ce_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = {2'b11, 47'h0};
        {periph_out_i, periph_oe_i, ext_en, ext_val} = {12'h000, 6'h3F, 6'h08};
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(8'h18, 8'h3F);
        rdc(8'h1C, 8'h37);
        rdc(8'h20, 8'h80);
        rdc(8'h24, 8'h00);
        chk("pullup", pullup_o, 9'h000);
        wb(1'b1, 8'h20, 8'h00);
        chk("pullup", pullup_o, 9'h037);
        wb(1'b1, 8'h18, 8'h00);
        rdc(8'h18, 8'h08);
        chk("oe", pin_oe_o, 9'h037);
        chk("pullup", pullup_o, 9'h000);
        wb(1'b1, 8'h14, 8'h15);
        repeat (3) @(posedge clk_i);
        chk("drive", pin_o & pin_oe_o, 9'h015);
        rdc(8'h14, 8'h1D);
        wb(1'b1, 8'h30, 8'h02);
        rdc(8'h14, 8'h15);
        wb(1'b1, 8'h30, 8'h00);
        wb(1'b1, 8'h28, 8'h01);
        rdc(8'h14, 8'h1C);
        wb(1'b1, 8'h28, 8'h00);
        wb(1'b0, 8'h3C, 8'h00);
        chk("unmapped err", e, 9'h001);
        periph_oe_i <= 6'h01;
        wb(1'b1, 8'h2C, 8'h01);
        chk("periph pin", {pin_oe_o[0], pin_o[0]}, 9'h002);
        periph_oe_i <= 6'h00;
        wb(1'b1, 8'h2C, 8'h00);
        wb(1'b1, 8'h18, 8'h3F);
        ext_val <= 6'h00;
        repeat (3) @(posedge clk_i);
        rdc(8'h14, 8'h00);
        wb(1'b1, 8'h24, 8'h3F);
        wb(1'b1, 8'h30, 8'h00);
        chk("flag", port_change_flag_o, 9'h000);
        ext_val <= 6'h04;
        repeat (5) @(posedge clk_i);
        chk("periph in", periph_in_o, 9'h004);
        chk("flag", port_change_flag_o, 9'h001);
        wb(1'b1, 8'h30, 8'h00);
        chk("flag", port_change_flag_o, 9'h001);
        rdc(8'h14, 8'h04);
        wb(1'b1, 8'h30, 8'h00);
        chk("flag", port_change_flag_o, 9'h000);
        // clock enable low: synchroniser and flag frozen
        ce_i <= 1'b0;
        ext_val <= 6'h00;
        repeat (5) @(posedge clk_i);
        chk("frozen flag", port_change_flag_o, 9'h000);
        ce_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        chk("flag", port_change_flag_o, 9'h001);
        final_report();
    end
endmodule

// File: verilog/spbp_port.sv
// spbp_port.sv: six-pin bidirectional general-purpose port with wishbone slave.
// assumes a classic wishbone master on clk_i; pins resolved outside from oe.
`timescale 1ns/1ps
`include "spbp_defs.svh"

module spbp_port #(
    parameter int NPINS = `SPBP_NPINS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    input wire logic [NPINS-1:0] pin_i,
    output logic [NPINS-1:0] pin_o,
    output logic [NPINS-1:0] pin_oe_o,
    output logic [NPINS-1:0] pullup_o,
    input wire logic [NPINS-1:0] periph_out_i,
    input wire logic [NPINS-1:0] periph_oe_i,
    output logic [NPINS-1:0] periph_in_o,
    output logic port_change_flag_o
);
    spbp_sync_if #(.NPINS(NPINS)) sync_bus ();

    spbp_sync #(.NPINS(NPINS)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .pin_i(pin_i),
        .sync_o(sync_bus)
    );

    localparam logic [NPINS-1:0] IN_ONLY = NPINS'(`SPBP_IN_ONLY_MASK);

    spbp_pkg::spbp_bus_state_t state_ff, nxt_state;
    logic [NPINS-1:0] latch_ff, nxt_latch;
    logic [NPINS-1:0] dir_ff, nxt_dir;
    logic [NPINS-1:0] pullup_en_ff, nxt_pullup_en;
    logic [NPINS-1:0] change_en_ff, nxt_change_en;
    logic [NPINS-1:0] analog_ff, nxt_analog;
    logic [NPINS-1:0] periph_en_ff, nxt_periph_en;
    logic [NPINS-1:0] last_read_ff, nxt_last_read;
    logic [7:0] option_ff, nxt_option;
    logic ext_reset_en_ff, nxt_ext_reset_en;
    logic flag_ff, nxt_flag;
    logic [31:0] rdata_ff, nxt_rdata;
    logic err_ff, nxt_err;

    logic [NPINS-1:0] port_view;
    logic [NPINS-1:0] dir_view;
    logic [NPINS-1:0] mismatch;
    logic req;
    logic [7:0] idx;

    function automatic logic [NPINS-1:0] merge(input logic [NPINS-1:0] old_v, input logic [7:0] wd,
                                               input logic lane0);
        merge = lane0 ? wd[NPINS-1:0] : old_v;
    endfunction

    function automatic logic [31:0] widen(input logic [NPINS-1:0] v);
        widen = {{(32-NPINS){1'b0}}, v};
    endfunction

    assign req = cyc_i && stb_i && (state_ff == spbp_pkg::SPBP_IDLE);
    assign idx = {2'b00, adr_i[7:2]};

    // what a port read sees: synchronised level, analog and peripheral pins read 0
    always_comb begin
        port_view = sync_bus.level & ~analog_ff & ~periph_en_ff;
        if (ext_reset_en_ff) begin
            port_view[`SPBP_IN_ONLY_BIT] = 1'b0;
        end
        dir_view = dir_ff | IN_ONLY;
        mismatch = (sync_bus.level ^ last_read_ff) & change_en_ff;
    end

    // pin drivers; direction bits gate even analog pins
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            if (periph_en_ff[i]) begin
                pin_o[i] = periph_out_i[i];
                pin_oe_o[i] = periph_oe_i[i] && !IN_ONLY[i];
            end else begin
                pin_o[i] = latch_ff[i];
                pin_oe_o[i] = !dir_view[i];
            end
            pullup_o[i] = pullup_en_ff[i] && !IN_ONLY[i] && !pin_oe_o[i]
                          && !option_ff[`SPBP_GLOBAL_PULLUP_BIT];
        end
        periph_in_o = sync_bus.level;
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_latch = latch_ff;
        nxt_dir = dir_ff;
        nxt_pullup_en = pullup_en_ff;
        nxt_change_en = change_en_ff;
        nxt_analog = analog_ff;
        nxt_periph_en = periph_en_ff;
        nxt_last_read = last_read_ff;
        nxt_option = option_ff;
        nxt_ext_reset_en = ext_reset_en_ff;
        nxt_rdata = rdata_ff;
        nxt_err = err_ff;
        nxt_flag = flag_ff;
        case (state_ff)
            spbp_pkg::SPBP_IDLE: begin
                if (req) begin
                    nxt_state = spbp_pkg::SPBP_ACK;
                    nxt_err = 1'b0;
                    nxt_rdata = 32'h0000_0000;
                    case (idx)
                        `SPBP_IDX_PORT_DATA: begin
                            nxt_rdata = widen(port_view);
                            nxt_last_read = sync_bus.level;
                            if (we_i) begin
                                // pin levels form the base; driven pins see their own latch value, analog and peripheral pins 0
                                nxt_latch = merge(port_view, dat_i[7:0], sel_i[0]);
                            end
                        end
                        `SPBP_IDX_DIR: begin
                            nxt_rdata = widen(dir_view);
                            if (we_i) nxt_dir = merge(dir_ff, dat_i[7:0], sel_i[0]) | IN_ONLY;
                        end
                        `SPBP_IDX_PULLUP: begin
                            nxt_rdata = widen(pullup_en_ff & ~IN_ONLY);
                            if (we_i) nxt_pullup_en = merge(pullup_en_ff, dat_i[7:0], sel_i[0]) & ~IN_ONLY;
                        end
                        `SPBP_IDX_OPTION: begin
                            nxt_rdata = {24'h00_0000, option_ff};
                            if (we_i && sel_i[0]) nxt_option = dat_i[7:0];
                        end
                        `SPBP_IDX_CHANGE_EN: begin
                            nxt_rdata = widen(change_en_ff);
                            if (we_i) nxt_change_en = merge(change_en_ff, dat_i[7:0], sel_i[0]);
                        end
                        `SPBP_IDX_ANALOG: begin
                            nxt_rdata = widen(analog_ff);
                            if (we_i) nxt_analog = merge(analog_ff, dat_i[7:0], sel_i[0]);
                        end
                        `SPBP_IDX_PERIPH: begin
                            nxt_rdata = widen(periph_en_ff);
                            if (we_i) nxt_periph_en = merge(periph_en_ff, dat_i[7:0], sel_i[0]);
                        end
                        `SPBP_IDX_STATUS: begin
                            nxt_rdata = {30'h0000_0000, ext_reset_en_ff, flag_ff};
                            if (we_i && sel_i[0]) begin
                                nxt_ext_reset_en = dat_i[1];
                                if (!dat_i[`SPBP_FLAG_BIT]) nxt_flag = 1'b0;
                            end
                        end
                        default: nxt_err = 1'b1;
                    endcase
                end
            end
            spbp_pkg::SPBP_ACK: nxt_state = spbp_pkg::SPBP_IDLE;
            default: nxt_state = spbp_pkg::SPBP_IDLE;
        endcase
        // set wins over a same-cycle clear; a standing mismatch keeps setting
        if (|mismatch) nxt_flag = 1'b1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= spbp_pkg::SPBP_IDLE;
            latch_ff <= '0;
            dir_ff <= NPINS'(`SPBP_DIR_RST);
            pullup_en_ff <= NPINS'(`SPBP_PULLUP_RST);
            change_en_ff <= '0;
            analog_ff <= '0;
            periph_en_ff <= '0;
            last_read_ff <= '0;
            option_ff <= `SPBP_OPTION_RST;
            ext_reset_en_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            err_ff <= 1'b0;
            flag_ff <= 1'b0;
        end else if (ce_i) begin
            state_ff <= nxt_state;
            latch_ff <= nxt_latch;
            dir_ff <= nxt_dir;
            pullup_en_ff <= nxt_pullup_en;
            change_en_ff <= nxt_change_en;
            analog_ff <= nxt_analog;
            periph_en_ff <= nxt_periph_en;
            last_read_ff <= nxt_last_read;
            option_ff <= nxt_option;
            ext_reset_en_ff <= nxt_ext_reset_en;
            rdata_ff <= nxt_rdata;
            err_ff <= nxt_err;
            flag_ff <= nxt_flag;
        end
    end

    assign ack_o = (state_ff == spbp_pkg::SPBP_ACK) && !err_ff;
    assign err_o = (state_ff == spbp_pkg::SPBP_ACK) && err_ff;
    assign dat_o = rdata_ff;
    assign port_change_flag_o = flag_ff;
endmodule

// File: verilog/spbp_sync.sv
// spbp_sync.sv: two-stage synchroniser for the pin levels.
// assumes clk_i is the core clock, rst_i synchronous active high.
`timescale 1ns/1ps
module spbp_sync #(
    parameter int NPINS = 6
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [NPINS-1:0] pin_i,
    spbp_sync_if.src sync_o
);
    logic [NPINS-1:0] meta_ff;
    logic [NPINS-1:0] sync_ff;
    logic [NPINS-1:0] nxt_meta;
    logic [NPINS-1:0] nxt_sync;

    always_comb begin
        nxt_meta = meta_ff;
        nxt_sync = sync_ff;
        if (ce_i) begin
            nxt_meta = pin_i;
            nxt_sync = meta_ff;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign sync_o.level = sync_ff;
endmodule
